/* sps_pkg.sv */
package sps_pkg;
   // ==========================================
   // sizes and reset values
   localparam int STAGES = 8;
   localparam logic [7:0] STAGE_RESET = 8'h00;
   localparam int SYNC_DEPTH = 3;
   localparam int FIFO_DEPTH = 8;
   typedef logic [STAGES-1:0] sps_word_t;
endpackage

/* sps_fifo_if.sv */
`timescale 1ns/1ps
interface sps_fifo_if #(parameter int WIDTH = 8) ();
   logic [WIDTH-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] out_data;
   logic out_valid;
   logic out_ready;
   modport fill (output in_data, output in_valid, input in_ready,
      input out_data, input out_valid, output out_ready);
   modport store (input in_data, input in_valid, output in_ready,
      output out_data, output out_valid, input out_ready);
endinterface

/* sps_fifo.sv */
`timescale 1ns/1ps
module sps_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   sps_fifo_if.store port
);
   localparam int AW = $clog2(DEPTH);
   // pointer wrap bit only works for power-of-two depths
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign port.in_ready = !full;
   assign port.out_valid = !empty;
   assign port.out_data = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr <= '0;
      end else if (port.in_valid && !full) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (port.in_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= port.in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_ptr <= '0;
      end else if (port.out_ready && !empty) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

/* sps_shifter.sv */
`timescale 1ns/1ps
module sps_shifter #(
   parameter int STAGE_COUNT = sps_pkg::STAGES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic shift_clock,
   input wire logic clear_n,
   input wire logic serial_in_a,
   input wire logic serial_in_b,
   output logic [STAGE_COUNT-1:0] parallel_out,
   output logic stage_out_first,
   output logic [STAGE_COUNT-1:0] snap_data,
   output logic snap_valid,
   input wire logic snap_ready
);
   import sps_pkg::*;
   // chain word type and checks are fixed to the package width
   if (STAGE_COUNT != STAGES) begin : g_bad_count
      $error("stage count must match the package width");
   end

   // ==========================================
   // pin synchronisers, three flops each
   logic [SYNC_DEPTH-1:0] sync_clk;
   logic [SYNC_DEPTH-1:0] sync_clr;
   logic [SYNC_DEPTH-1:0] sync_a;
   logic [SYNC_DEPTH-1:0] sync_b;
   logic clk_level;
   logic clr_level;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync_clk <= '0;
         sync_clr <= '0;
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_clk <= {sync_clk[1:0], shift_clock};
         sync_clr <= {sync_clr[1:0], clear_n};
         sync_a <= {sync_a[1:0], serial_in_a};
         sync_b <= {sync_b[1:0], serial_in_b};
      end
   end
   // a change counts once the second and third flops agree
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clk_level <= 1'b0;
         clr_level <= 1'b0;
      end else begin
         if (sync_clk[1] == sync_clk[2]) begin
            clk_level <= sync_clk[2];
         end
         if (sync_clr[1] == sync_clr[2]) begin
            clr_level <= sync_clr[2];
         end
      end
   end
   // data is sampled a cycle behind the edge, like a hold window
   logic clk_prev;
   logic rise;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clk_prev <= 1'b0;
      end else begin
         clk_prev <= clk_level;
      end
   end
   assign rise = clk_level && !clk_prev;

   // ==========================================
   // shift chain
   // clear taken straight from the third flop too, so it acts without the
   // agree filter delay; clear is level so the filter buys nothing here
   logic clear_now;
   assign clear_now = !sync_clr[2] || !clr_level;
   sps_word_t stage;
   sps_word_t next_stage;
   always_comb begin
      next_stage = stage;
      if (clear_now) begin
         next_stage = STAGE_RESET;
      end else if (rise) begin
         next_stage = {stage[STAGES-2:0], sync_a[2] & sync_b[2]};
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stage <= STAGE_RESET;
      end else begin
         stage <= next_stage;
      end
   end
   assign parallel_out = stage;
   assign stage_out_first = stage[0];

   // ==========================================
   // each shift pushes the new word; while the fifo is full it waits in snap_data and the next shift overwrites it, the chain never waits
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         snap_valid <= 1'b0;
         snap_data <= STAGE_RESET;
      end else if (!clear_now && rise) begin
         snap_valid <= 1'b1;
         snap_data <= next_stage;
      end else if (snap_ready) begin
         snap_valid <= 1'b0;
      end
   end

   a_clear_zero: assert property (@(posedge clk) disable iff (!rst_b)
      clear_now |=> stage == STAGE_RESET) else $error("clear did not zero");
   a_clear_hold: assert property (@(posedge clk) disable iff (!rst_b)
      clear_now && rise |=> stage == 8'h00) else $error("edge moved chain in clear");
   a_shift_move: assert property (@(posedge clk) disable iff (!rst_b)
      !clear_now && rise |=> stage[7:1] == $past(stage[6:0])) else $error("bad shift");
   a_first_and: assert property (@(posedge clk) disable iff (!rst_b)
      !clear_now && rise |=> stage[0] == $past(sync_a[2] & sync_b[2]))
      else $error("bad first stage");
   a_idle_keep: assert property (@(posedge clk) disable iff (!rst_b)
      !clear_now && !rise |=> $stable(stage)) else $error("chain moved without edge");
   a_edge_only: assert property (@(posedge clk) disable iff (!rst_b)
      !$stable(stage) |-> $past(clear_now || rise)) else $error("change without cause");
   a_par_view: assert property (@(posedge clk) disable iff (!rst_b)
      stage_out_first == parallel_out[0]) else $error("first stage view mismatch");
   a_snap_push: assert property (@(posedge clk) disable iff (!rst_b)
      !clear_now && rise |=> snap_valid && snap_data == stage) else $error("no push");
endmodule

/* sps_top.sv */
`timescale 1ns/1ps
module sps_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic shift_clock,
   input wire logic clear_n,
   input wire logic serial_in_a,
   input wire logic serial_in_b,
   output logic [sps_pkg::STAGES-1:0] parallel_out,
   output logic stage_out_first,
   output logic [sps_pkg::STAGES-1:0] word_data,
   output logic word_valid,
   input wire logic word_ready
);
   import sps_pkg::*;
   sps_fifo_if #(.WIDTH(STAGES)) link ();
   sps_word_t par;
   logic first;
   sps_shifter #(.STAGE_COUNT(STAGES)) u_shift (
      .clk(clk),
      .rst_b(rst_b),
      .shift_clock(shift_clock),
      .clear_n(clear_n),
      .serial_in_a(serial_in_a),
      .serial_in_b(serial_in_b),
      .parallel_out(par),
      .stage_out_first(first),
      .snap_data(link.in_data),
      .snap_valid(link.in_valid),
      .snap_ready(link.in_ready)
   );
   sps_fifo #(.WIDTH(STAGES), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .port(link.store)
   );
   // outputs registered; the fifo head moves into a one-word output slot
   assign link.out_ready = !word_valid || word_ready;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         parallel_out <= STAGE_RESET;
         stage_out_first <= 1'b0;
         word_valid <= 1'b0;
         word_data <= STAGE_RESET;
      end else begin
         parallel_out <= par;
         stage_out_first <= first;
         if (link.out_ready) begin
            word_valid <= link.out_valid;
            word_data <= link.out_data;
         end
      end
   end
endmodule

/* sps_upstream.sv */
`timescale 1ns/1ps
// ==========
// upstream pin driver
module sps_upstream (
   input wire logic clk,
   output logic shift_clock,
   output logic clear_n,
   output logic serial_in_a,
   output logic serial_in_b
);
   initial begin
      shift_clock = 1'b0;
      clear_n = 1'b1;
      serial_in_a = 1'b0;
      serial_in_b = 1'b0;
   end
   task automatic set_data(input logic a, input logic b, input int n);
      serial_in_a <= a;
      serial_in_b <= b;
      repeat (n) @(posedge clk);
   endtask
   // data steady 4 clk around the rise, pulses wide enough for the synchronisers
   task automatic shift(input logic a, input logic b);
      set_data(a, b, 4);
      shift_clock <= 1'b1;
      repeat (4) @(posedge clk);
      shift_clock <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic set_clear(input logic c);
      clear_n <= c;
      repeat (8) @(posedge clk);
   endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import sps_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic word_ready = 1'b1;
   wire shift_clock, clear_n, serial_in_a, serial_in_b;
   sps_word_t parallel_out, word_data, chain;
   logic stage_out_first, word_valid;
   sps_word_t rx[$], expq[$];
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   sps_upstream UP (.clk(clk), .shift_clock(shift_clock), .clear_n(clear_n),
      .serial_in_a(serial_in_a), .serial_in_b(serial_in_b));
   sps_top DUT (.clk(clk), .rst_b(rst_b), .shift_clock(shift_clock), .clear_n(clear_n),
      .serial_in_a(serial_in_a), .serial_in_b(serial_in_b), .parallel_out(parallel_out),
      .stage_out_first(stage_out_first), .word_data(word_data), .word_valid(word_valid),
      .word_ready(word_ready));
   // ==========
   // word capture and hang limit
   always @(posedge clk) begin
      if (rst_b && word_valid === 1'b1 && word_ready) rx.push_back(word_data);
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic check(input string what, input sps_word_t exp, input sps_word_t got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input logic a, input logic b);
      UP.shift(a, b);
      if (clear_n === 1'b1) begin
         chain = {chain[6:0], a & b};
         expq.push_back(chain);
      end
      @(posedge clk);
      check("parallel_out", chain, parallel_out);
      check("stage_out_first", {7'h00, chain[0]}, {7'h00, stage_out_first});
   endtask
   task automatic check_words(input int n);
      repeat (20) @(posedge clk);
      check("word_count", sps_word_t'(n), sps_word_t'(rx.size()));
      for (int i = 0; i < n && i < rx.size(); i++) check("word_data", expq[i], rx[i]);
      rx.delete();
      expq.delete();
   endtask
   // ==========
   // scenarios
   task automatic t_shift();
      for (int i = 0; i < 8; i++) step(1'b1, i[0] ^ i[2]);
      for (int i = 0; i < 4; i++) step(~i[1], 1'b1);
      check_words(12);
      $display("test shift done");
   endtask
   task automatic t_gate();
      for (int i = 7; i >= 0; i--) step(i[1], i[0]);
      check_words(8);
      $display("test gate done");
   endtask
   task automatic t_hold();
      UP.set_data(1'b1, 1'b1, 10);
      UP.set_data(1'b0, 1'b1, 10);
      check("parallel_out", chain, parallel_out);
      check_words(0);
      $display("test hold done");
   endtask
   task automatic t_clear();
      UP.set_clear(1'b0);
      chain = STAGE_RESET;
      check("parallel_out", chain, parallel_out);
      step(1'b1, 1'b1);
      UP.set_clear(1'b1);
      check("word_count", 8'h00, sps_word_t'(rx.size()));
      step(1'b1, 1'b1);
      check_words(1);
      $display("test clear done");
   endtask
   task automatic t_fill();
      word_ready <= 1'b0;
      for (int i = 0; i < 10; i++) step(1'b1, i[0]);
      word_ready <= 1'b1;
      repeat (30) @(posedge clk);
      // depth beyond 8 depends on the output slot, so only the oldest 8 are judged
      while (rx.size() > 8) void'(rx.pop_back());
      check_words(8);
      $display("test fill done");
   endtask
   task automatic end_of_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      chain = STAGE_RESET;
      t_shift();
      t_gate();
      t_hold();
      t_clear();
      t_fill();
      end_of_test();
   end
endmodule
